// ===== verilog/dsd_decoder.sv
// Data-space decoder with program-memory window, RAM and return stack
`timescale 1ns/1ps
`default_nettype none
module dsd_decoder (
  input  wire logic                 mclk,          // Core clock
  input  wire logic                 rst,           // Async reset, high
  input  wire dsd_pkg::dsd_acc_s    acc,           // CPU data access
  output logic [7:0]                rdata,         // Read data, combinational same cycle
  input  wire logic [7:0]           pmem_rdata,    // Program memory byte
  output logic [dsd_pkg::PC_W-1:0]  pmem_addr,     // Program memory address
  output logic                      pmem_rd,       // Program memory window read
  input  wire logic [7:0]           bank_rdata,    // Selected bank read data
  output logic                      bank_sel_ram2, // RAM page 2 selected
  output logic                      bank_sel_ee0,  // EEPROM page 0 selected
  output logic                      bank_rd,       // Bank region read
  output logic                      bank_wr,       // Bank region write
  output logic [5:0]                bank_addr,     // Offset in bank
  input  wire logic [7:0]           core_rdata,    // Core register read data
  output logic                      core_sel,      // Core register slot
  output logic [1:0]                core_idx,      // 0 X,1 Y,2 V,3 W
  input  wire logic [7:0]           peri_rdata,    // Peripheral read data
  output logic                      peri_sel,      // Peripheral slot
  output logic                      pa_dir_sel,    // Port A direction slot
  input  wire logic                 stk_push,      // Push return address
  input  wire logic                 stk_pop,       // Pop return address
  input  wire logic [dsd_pkg::PC_W-1:0] stk_wdata, // Address to push
  output logic [dsd_pkg::PC_W-1:0]  stk_top,       // Top of stack
  input  wire logic                 prot_opt,      // Readout protection option
  input  wire logic                 ext_rd,        // External readout request
  input  wire logic [dsd_pkg::PC_W-1:0] ext_addr,  // External readout address
  output logic [7:0]                ext_rdata      // External readout data
);
  import dsd_pkg::*;

  dsd_region_e           region;        // Decoded region
  logic [WINPOS_W-1:0]   winpos_q;      // Window position, no reset
  logic [7:0]            banksel_q;     // Bank select, no reset
  logic [7:0]            ram_q [RAM_BYTES]; // General RAM
  logic [PC_W-1:0]       stk_q [STACK_DEPTH]; // Return stack
  logic [5:0]            ram_idx;       // RAM word index
  logic                  ext_path;      // External readout owns program address

  // Address classification
  always_comb begin
    region = dsd_decode(acc.addr);
  end

  assign ram_idx = 6'(acc.addr - RAM_LO);

  // Window position register, undefined until written
  always_ff @(posedge mclk) begin
    if (acc.wr && acc.addr == WINPOS_ADDR) begin
      winpos_q <= acc.wdata[WINPOS_W-1:0];
    end
  end

  // Bank select register, write-only, undefined until written
  always_ff @(posedge mclk) begin
    if (acc.wr && acc.addr == BANKSEL_ADDR) begin
      banksel_q <= acc.wdata;
    end
  end

  // General RAM, 60 bytes
  always_ff @(posedge mclk) begin
    if (acc.wr && region == DSD_R_RAM) begin
      ram_q[ram_idx] <= acc.wdata;
    end
  end

  // Window address: position over offset, 64-byte steps
  // External readout borrows the program address only when no window read runs
  assign ext_path  = ext_rd && !pmem_rd;
  assign pmem_addr = ext_path ? ext_addr
                              : {winpos_q, acc.addr[OFS_W-1:0]};
  assign pmem_rd   = acc.rd && region == DSD_R_WIN;

  // Bank region strobes
  assign bank_sel_ram2 = banksel_q[BANK_RAM2_BIT];
  assign bank_sel_ee0  = banksel_q[BANK_EE0_BIT];
  assign bank_rd   = acc.rd && region == DSD_R_BANK;
  assign bank_wr   = acc.wr && region == DSD_R_BANK;
  assign bank_addr = acc.addr[5:0];

  // Core and peripheral slots
  assign core_sel   = region == DSD_R_CORE;
  assign core_idx   = acc.addr[1:0];
  assign peri_sel   = region == DSD_R_PERI;
  assign pa_dir_sel = acc.addr == PA_DIR_ADDR;

  // Read mux, same cycle as RAM
  always_comb begin
    case (region)
      DSD_R_BANK: rdata = bank_rdata;
      DSD_R_WIN:  rdata = pmem_rdata;
      DSD_R_CORE: rdata = core_rdata;
      DSD_R_RAM:  rdata = ram_q[ram_idx];
      DSD_R_PERI: rdata = peri_rdata;
      DSD_R_WREG: rdata = 8'h00;               // Write-only reads as zero
      default:    rdata = 8'h00;
    endcase
  end

  // Return stack, shift register of six entries
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STACK_DEPTH; i++) stk_q[i] <= 12'h000;
    end else if (stk_push) begin
      stk_q[0] <= stk_wdata;
      for (int i = 1; i < STACK_DEPTH; i++) stk_q[i] <= stk_q[i-1];
    end else if (stk_pop) begin
      for (int i = 0; i < STACK_DEPTH-1; i++) stk_q[i] <= stk_q[i+1];
    end
  end
  assign stk_top = stk_q[0];

  // External readout, blocked when protected
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_rdata <= 8'h00;
    end else if (ext_path) begin
      ext_rdata <= prot_opt ? 8'h00 : pmem_rdata;
    end
  end

  // Access steps that the multi-cycle checks are built from
  // Write of the window position register
  sequence winpos_write_s;
    acc.wr && acc.addr == WINPOS_ADDR;
  endsequence : winpos_write_s

  // Read inside the program-memory window
  sequence win_read_s;
    acc.rd && acc.addr >= WIN_LO && acc.addr <= WIN_HI;
  endsequence : win_read_s

  // Write to the first general RAM byte
  sequence ram_lo_write_s;
    acc.wr && acc.addr == RAM_LO;
  endsequence : ram_lo_write_s

  // Fresh read of the first general RAM byte
  sequence ram_lo_read_s;
    acc.rd && acc.addr == RAM_LO && !$past(acc.rd);
  endsequence : ram_lo_read_s

  // Window read returns program byte in the same cycle
  win_read_a: assert property (@(posedge mclk) disable iff (rst)
    win_read_s |->
      pmem_rd && rdata == pmem_rdata) else $error("window read not routed");

  // Window strobe never fires outside the window
  win_only_a: assert property (@(posedge mclk) disable iff (rst)
    pmem_rd |-> acc.rd && acc.addr >= WIN_LO && acc.addr <= WIN_HI)
    else $error("window strobe outside window");

  // Low address bits pass straight into the program address
  win_addr_a: assert property (@(posedge mclk) disable iff (rst)
    pmem_rd |-> pmem_addr[5:0] == acc.addr[5:0]) else $error("window offset wrong");

  // Position written just before is used by the next window read
  win_pos_a: assert property (@(posedge mclk) disable iff (rst)
    winpos_write_s ##1 win_read_s |->
      pmem_addr[11:6] == $past(acc.wdata[5:0])) else $error("position not applied");

  // Window read keeps working while an external readout is requested
  win_ext_a: assert property (@(posedge mclk) disable iff (rst)
    ext_rd && pmem_rd |-> pmem_addr[5:0] == acc.addr[5:0])
    else $error("window lost to readout");

  // Write-only position register hides its contents
  winpos_read_a: assert property (@(posedge mclk) disable iff (rst)
    acc.rd && acc.addr == WINPOS_ADDR |-> rdata == 8'h00) else $error("position readable");

  // Bank region reads go to the selected bank
  bank_route_a: assert property (@(posedge mclk) disable iff (rst)
    acc.rd && acc.addr <= BANK_HI |-> bank_rd && !pmem_rd) else $error("bank not routed");

  // Bank region writes carry the offset to the bank
  bank_wr_a: assert property (@(posedge mclk) disable iff (rst)
    acc.wr && acc.addr <= BANK_HI |-> bank_wr && bank_addr == acc.addr[5:0])
    else $error("bank write not routed");

  // RAM byte written is read back on the next cycle
  ram_back_a: assert property (@(posedge mclk) disable iff (rst)
    ram_lo_write_s ##1 ram_lo_read_s |->
      rdata == $past(acc.wdata)) else $error("ram readback wrong");

  // Second index register decodes to its own slot
  core_idx_a: assert property (@(posedge mclk) disable iff (rst)
    acc.addr == IDX_Y_ADDR |-> core_sel && core_idx == 2'd1) else $error("index decode");

  // First index register decodes to slot zero
  core_x_a: assert property (@(posedge mclk) disable iff (rst)
    acc.addr == IDX_X_ADDR |-> core_sel && core_idx == 2'd0) else $error("index x decode");

  // Port A direction sits in the peripheral block
  pa_dir_a: assert property (@(posedge mclk) disable iff (rst)
    pa_dir_sel |-> acc.addr == 8'hc4 && peri_sel) else $error("port A dir decode");

  // Peripheral slot excludes the core, window and bank regions
  peri_excl_a: assert property (@(posedge mclk) disable iff (rst)
    peri_sel |-> !core_sel && !pmem_rd && !bank_rd) else $error("peripheral overlap");

  // Pushed address appears on top next cycle
  stack_a: assert property (@(posedge mclk) disable iff (rst)
    stk_push |=> stk_top == $past(stk_wdata)) else $error("stack push lost");

  // Pop brings the second entry to the top
  stack_pop_a: assert property (@(posedge mclk) disable iff (rst)
    stk_pop && !stk_push |=> stk_top == $past(stk_q[1])) else $error("stack pop wrong");

  // Protected part returns zero to external readout
  protect_a: assert property (@(posedge mclk) disable iff (rst)
    ext_rd && !pmem_rd && prot_opt |=> ext_rdata == 8'h00) else $error("readout leaked");

  // Unprotected part returns the addressed program byte
  readout_a: assert property (@(posedge mclk) disable iff (rst)
    ext_rd && !pmem_rd && !prot_opt |=> ext_rdata == $past(pmem_rdata))
    else $error("readout data wrong");

  // RAM page 2 select bit follows the last write
  banksel_a: assert property (@(posedge mclk) disable iff (rst)
    acc.wr && acc.addr == BANKSEL_ADDR |=> bank_sel_ram2 == $past(acc.wdata[4]))
    else $error("bank select wrong");

  // EEPROM page select bit follows the last write
  ee0_sel_a: assert property (@(posedge mclk) disable iff (rst)
    acc.wr && acc.addr == BANKSEL_ADDR |=> bank_sel_ee0 == $past(acc.wdata[0]))
    else $error("eeprom select wrong");

  // Write-only bank select hides its contents
  banksel_read_a: assert property (@(posedge mclk) disable iff (rst)
    acc.rd && acc.addr == BANKSEL_ADDR |-> rdata == 8'h00) else $error("bank select readable");
endmodule : dsd_decoder
`default_nettype wire

// ===== verilog/dsd_pkg.sv
// Package for the data-space decoder: address map, field layout, sizes
// Summary of operation
// - Reads 40h-7Fh come from program-memory window
// - Window address is position bits over offset
// - Window spans 0000h-0FFFh in 64-byte steps
// - Position bits 5-0 used, bits 7-6 ignored
// - Window position at C9h is write-only
// - Window position not cleared at reset
// - Addresses 00h-3Fh go to selected bank
// - Sixty bytes of general-purpose RAM
// - Index registers decoded at 80h and 81h
// - Port A direction register at C4h
// - Return stack of six 12-bit entries
// - Program space uses 12-bit counter
// - Readout protection blocks external reads only
// - Bank select write-only at E8h, bits 4/0
package dsd_pkg;
  localparam logic [7:0] BANK_LO     = 8'h00;  // Bank region start
  localparam logic [7:0] BANK_HI     = 8'h3f;  // Bank region end
  localparam logic [7:0] WIN_LO      = 8'h40;  // Window region start
  localparam logic [7:0] WIN_HI      = 8'h7f;  // Window region end
  localparam logic [7:0] IDX_X_ADDR  = 8'h80;  // First index register
  localparam logic [7:0] IDX_Y_ADDR  = 8'h81;  // Second index register
  localparam logic [7:0] SDIR_V_ADDR = 8'h82;  // First short-direct register
  localparam logic [7:0] SDIR_W_ADDR = 8'h83;  // Second short-direct register
  localparam logic [7:0] RAM_LO      = 8'h84;  // General RAM start
  localparam logic [7:0] RAM_HI      = 8'hbf;  // General RAM end
  localparam logic [7:0] PA_DIR_ADDR = 8'hc4;  // Port A direction register
  localparam logic [7:0] WINPOS_ADDR = 8'hc9;  // Window position register
  localparam logic [7:0] BANKSEL_ADDR = 8'he8; // Bank page select register
  localparam int         WINPOS_W    = 6;      // Meaningful position bits
  localparam int         OFS_W       = 6;      // Offset bits inside window
  localparam int         PC_W        = 12;     // Program counter width
  localparam int         RAM_BYTES   = 60;     // General RAM size
  localparam int         STACK_DEPTH = 6;      // Return stack levels
  localparam int         BANK_RAM2_BIT = 4;    // Selects RAM page 2
  localparam int         BANK_EE0_BIT  = 0;    // Selects EEPROM page 0

  // Region the current data address falls in
  typedef enum logic [6:0] {
    DSD_R_BANK = 7'b0000001,
    DSD_R_WIN  = 7'b0000010,
    DSD_R_CORE = 7'b0000100,
    DSD_R_RAM  = 7'b0001000,
    DSD_R_PERI = 7'b0010000,
    DSD_R_WREG = 7'b0100000,
    DSD_R_NONE = 7'b1000000
  } dsd_region_e;

  // One CPU data-space access
  typedef struct packed {
    logic       rd;    // Read strobe
    logic       wr;    // Write strobe
    logic [7:0] addr;  // Data address
    logic [7:0] wdata; // Write data
  } dsd_acc_s;

  // Classify an address; used for both read and write decode
  function automatic dsd_region_e dsd_decode(input logic [7:0] a);
    if (a <= BANK_HI) return DSD_R_BANK;
    else if (a <= WIN_HI) return DSD_R_WIN;
    else if (a <= SDIR_W_ADDR) return DSD_R_CORE;
    else if (a <= RAM_HI) return DSD_R_RAM;
    else if (a == WINPOS_ADDR || a == BANKSEL_ADDR) return DSD_R_WREG;
    else return DSD_R_PERI;
  endfunction : dsd_decode
endpackage : dsd_pkg

// ===== sim/dsd_mem_model.sv
// Behavioural memories and register sources around the decoder
`timescale 1ns/1ps
`default_nettype none
module dsd_mem_model (
  input  wire logic [11:0] pmem_addr,  // Program address
  output logic [7:0]       pmem_rdata, // Program byte
  input  wire logic [5:0]  bank_addr,  // Bank offset
  output logic [7:0]       bank_rdata, // Bank byte
  input  wire logic [1:0]  core_idx,   // Core register index
  output logic [7:0]       core_rdata, // Core register byte
  output logic [7:0]       peri_rdata  // Peripheral byte
);
  // Program bytes hash all twelve address bits
  assign pmem_rdata = pmem_addr[7:0] ^ {pmem_addr[11:8], 4'h5};
  // Bank bytes mark the 64-byte offset
  assign bank_rdata = {2'b10, bank_addr};
  assign core_rdata = {6'h30, core_idx};   // Index tagged byte
  assign peri_rdata = 8'h77;               // Fixed peripheral byte
endmodule : dsd_mem_model
`default_nettype wire

// ===== sim/tb_dsd_decoder.sv
// Self-checking testbench for the data-space decoder
`timescale 1ns/1ps
`default_nettype none
module tb_dsd_decoder;
  import dsd_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, stk_push = 1'b0, stk_pop = 1'b0;
  logic prot_opt = 1'b1, ext_rd = 1'b0;
  logic [11:0] stk_wdata = 12'h000, ext_addr = 12'h000, pmem_addr, stk_top;
  logic [7:0]  rdata, pmem_rdata, bank_rdata, core_rdata, peri_rdata, ext_rdata;
  logic [5:0]  bank_addr;
  logic [1:0]  core_idx;
  logic        pmem_rd, bank_sel_ram2, bank_sel_ee0, bank_rd, bank_wr;
  logic        core_sel, peri_sel, pa_dir_sel;
  dsd_acc_s    acc = '0;                // CPU access
  int          err_total = 0, comparisons = 0;
  dsd_decoder i_dut (.mclk(mclk), .rst(rst), .acc(acc), .rdata(rdata),
    .pmem_rdata(pmem_rdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .bank_rdata(bank_rdata), .bank_sel_ram2(bank_sel_ram2), .bank_sel_ee0(bank_sel_ee0),
    .bank_rd(bank_rd), .bank_wr(bank_wr), .bank_addr(bank_addr), .core_rdata(core_rdata),
    .core_sel(core_sel), .core_idx(core_idx), .peri_rdata(peri_rdata), .peri_sel(peri_sel),
    .pa_dir_sel(pa_dir_sel), .stk_push(stk_push), .stk_pop(stk_pop), .stk_wdata(stk_wdata),
    .stk_top(stk_top), .prot_opt(prot_opt), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .ext_rdata(ext_rdata));
  dsd_mem_model i_mem (.pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .bank_addr(bank_addr), .bank_rdata(bank_rdata), .core_idx(core_idx),
    .core_rdata(core_rdata), .peri_rdata(peri_rdata));
  // Clock at 50 ns period
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Compare one value, report a mismatch
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) acc <= {1'b0, 1'b1, a, d};
    @(posedge mclk) acc <= '0;
  endtask : wr
  // Read strobe, sampled once settled
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) acc <= {1'b1, 1'b0, a, 8'h00};
    #10;
  endtask : rd
  // Write then read on the very next edge
  task automatic wr_rd(input logic [7:0] aw, input logic [7:0] d, input logic [7:0] ar);
    @(posedge mclk) acc <= {1'b0, 1'b1, aw, d};
    @(posedge mclk) acc <= {1'b1, 1'b0, ar, 8'h00};
    #10;
  endtask : wr_rd
  // Verdict and end of run
  task automatic complete_run;
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    #100us;
    err_total++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    wr(WINPOS_ADDR, 8'h28);
    rd(8'h59);
    chk("pmem_addr", 12'ha19, pmem_addr);
    chk("pmem_rd", 12'h001, {11'h0, pmem_rd});
    chk("win_rdata", {4'h0, 8'h19 ^ 8'ha5}, {4'h0, rdata});
    wr(WINPOS_ADDR, 8'hff);
    rd(WIN_HI);
    chk("pmem_top", 12'hfff, pmem_addr);
    wr(WINPOS_ADDR, 8'h00);
    rd(WIN_LO);
    chk("pmem_base", 12'h000, pmem_addr);
    rd(WINPOS_ADDR);
    chk("winpos_rd", 12'h000, {4'h0, rdata});
    wr(BANKSEL_ADDR, 8'h10);
    rd(8'h05);
    chk("ram2_sel", 12'h002, {10'h0, bank_sel_ram2, bank_sel_ee0});
    chk("bank_rdata", 12'h185, {3'h0, bank_rd, rdata});
    @(posedge mclk) acc <= {1'b0, 1'b1, 8'h07, 8'h00};
    #10;
    chk("bank_wr", 12'h107, {3'h0, bank_wr, 2'b00, bank_addr});
    wr(BANKSEL_ADDR, 8'h01);
    rd(BANKSEL_ADDR);
    chk("ee0_sel", 12'h100, {2'h0, bank_sel_ram2, bank_sel_ee0, rdata});
    wr(RAM_LO, 8'ha5);
    wr(RAM_HI, 8'h5a);
    rd(RAM_LO);
    chk("ram_lo", 12'h0a5, {4'h0, rdata});
    rd(RAM_HI);
    chk("ram_hi", 12'h05a, {4'h0, rdata});
    rd(IDX_Y_ADDR);
    chk("idx_y", 12'hdc1, {1'b1, core_sel, core_idx, rdata});
    rd(PA_DIR_ADDR);
    chk("pa_dir", 12'h377, {2'h0, pa_dir_sel, peri_sel, rdata});
    @(posedge mclk) acc <= '0;
    stk_push <= 1'b1;
    stk_wdata <= 12'h123;
    @(posedge mclk) stk_wdata <= 12'h456;
    ext_rd <= 1'b1;
    @(posedge mclk) stk_push <= 1'b0;
    ext_rd <= 1'b0;
    #10;
    chk("stk_push", 12'h456, stk_top);
    chk("ext_prot", 12'h000, {4'h0, ext_rdata});
    @(posedge mclk) stk_pop <= 1'b1;
    @(posedge mclk) stk_pop <= 1'b0;
    #10;
    chk("stk_pop", 12'h123, stk_top);
    wr_rd(WINPOS_ADDR, 8'h45, 8'h47);
    chk("b2b_addr", 12'h147, pmem_addr);
    chk("b2b_data", 12'h052, {4'h0, rdata});
    wr_rd(RAM_LO, 8'h3c, RAM_LO);
    chk("ram_b2b", 12'h03c, {4'h0, rdata});
    @(posedge mclk) acc <= '0;
    prot_opt <= 1'b0;
    ext_addr <= 12'h3c2;
    ext_rd <= 1'b1;
    @(posedge mclk) ext_rd <= 1'b0;
    #10;
    chk("ext_open", 12'h0f7, {4'h0, ext_rdata});
    complete_run();
  end
endmodule : tb_dsd_decoder
`default_nettype wire
